/* File: inc/slave_port_cfg.svh */
`ifndef SLAVE_PORT_CFG_SVH
`define SLAVE_PORT_CFG_SVH

// ----------------------------------------
// Slave-side register addresses
// ----------------------------------------
`define ADDR_STAT   16'h1ff8
`define ADDR_CMD    16'h1ffa
`define ADDR_CTRL   16'h1ffb
`define ADDR_IN     16'h1ffc
`define ADDR_OUT    16'h1ffd

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_RESET    8'h00
`define CTRL_WMASK    8'h1f
`define CTRL_SHARED   4
`define CTRL_EN       3
`define CTRL_SELSRC   2
`define CTRL_IBEMASK  1
`define CTRL_OBFMASK  0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_TOP   7
`define STAT_SFLO  3
`define STAT_CBE   2
`define STAT_IBE   1
`define STAT_OBF   0

`endif

/* File: inc/slave_port_pkg.sv */
package slave_port_pkg;

  // Index of each slave-side register in decode vectors
  typedef enum logic [2:0]
  {
    RI_CMD  = 3'b000,
    RI_STAT = 3'b001,
    RI_CTRL = 3'b010,
    RI_IN   = 3'b011,
    RI_OUT  = 3'b100
  } reg_idx_t;

  localparam int NUM_REGS = 5;

  // Pin sampler state
  typedef struct packed {
    logic       ale_q;      // Previous latch strobe level
    logic       rd_n_q;     // Previous read strobe level
    logic       wr_n_q;     // Previous write strobe level
    logic       cs_n_q;     // Previous chip select level
    logic       abit_q;     // Previous address bit pin level
    logic [7:0] data_q;     // Previous bus byte
    logic       ale_fall;   // Address capture pulse
    logic       rd_rise;    // Master read done pulse
    logic       wr_rise;    // Master write done pulse
    logic       rd_active;  // Master read in progress
    logic       grp_sel;    // Register group select
    logic [7:0] byte_val;   // Byte tied to the pulses
  } sampler_st_t;

  // Slave register decoder state
  typedef struct packed {
    logic [NUM_REGS-1:0] wr_hit;  // One-hot write pulse
    logic [NUM_REGS-1:0] rd_hit;  // One-hot read pulse
    logic [7:0]          wdata;   // Write data
  } decode_st_t;

  // Port core state
  typedef struct packed {
    logic [7:0] ctrl;     // Control register
    logic [7:0] cmd;      // Command byte register
    logic [7:0] inb;      // Inbound data register
    logic [7:0] outb;     // Outbound data register
    logic [4:0] sf;       // Status field bits
    logic       smo;      // Last shared access was read
    logic       cbe;      // Command buffer empty
    logic       inbound_buffer_empty;      // Inbound buffer empty
    logic       outbound_buffer_full;      // Outbound buffer full
    logic       notify;   // Host notify level
    logic       oe;       // Bus drive enable
    logic [7:0] dout;     // Bus drive byte
    logic [7:0] rdata;    // Slave read data
    logic       cbf_ev;   // Command full event
    logic       ibf_ev;   // Inbound full event
    logic       obe_ev;   // Outbound empty event
  } core_st_t;

endpackage : slave_port_pkg

/* File: inc/pin_event_if.sv */
`timescale 1ns/1ns
// Master-side events from the pin sampler to the core
interface pin_event_if;
  logic       ale_fall;   // Address capture pulse
  logic       rd_rise;    // Master read done pulse
  logic       wr_rise;    // Master write done pulse
  logic       rd_active;  // Master read in progress
  logic       grp_sel;    // Register group select
  logic [7:0] byte_val;   // Captured byte
  modport src (output ale_fall, rd_rise, wr_rise, rd_active,
                      grp_sel, byte_val);
  modport dst (input  ale_fall, rd_rise, wr_rise, rd_active,
                      grp_sel, byte_val);
endinterface : pin_event_if

/* File: inc/cpu_access_if.sv */
`timescale 1ns/1ns
// Decoded slave register accesses
interface cpu_access_if;
  logic [4:0] wr_hit;  // One-hot write pulse
  logic [4:0] rd_hit;  // One-hot read pulse
  logic [7:0] wdata;   // Write data
  modport src (output wr_hit, rd_hit, wdata);
  modport dst (input  wr_hit, rd_hit, wdata);
endinterface : cpu_access_if

/* File: hdl/host_pin_sampler.sv */
`timescale 1ns/1ns
`include "slave_port_cfg.svh"
module host_pin_sampler
  import slave_port_pkg::*;
(
  input  wire logic       clk_sys,      // System clock
  input  wire logic       sys_rst,      // Async reset
  input  wire logic       ale,          // Address latch strobe
  input  wire logic       rd_n,         // Read strobe
  input  wire logic       wr_n,         // Write strobe
  input  wire logic       cs_n,         // Chip select
  input  wire logic       abit,         // Address bit pin
  input  wire logic [7:0] data_in,      // Bus byte
  input  wire logic       port_on,      // Port enable bit
  input  wire logic       shared,       // Shared mode
  input  wire logic       sel_src,      // Select source bit
  pin_event_if.src        ev            // Event outputs
);

  sampler_st_t st_r;   // Registered state
  sampler_st_t st_nxt; // Next state
  logic        qual;   // Strobes accepted

  // ----------------------------------------
  // Edge detection and qualification
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    // Strobes count only while selected and enabled
    qual = !st_r.cs_n_q && port_on;
    st_nxt.ale_q  = ale;
    st_nxt.rd_n_q = rd_n;
    st_nxt.wr_n_q = wr_n;
    st_nxt.cs_n_q = cs_n;
    st_nxt.abit_q = abit;
    st_nxt.data_q = data_in;
    // Address from the muxed bus on latch fall
    st_nxt.ale_fall = qual && shared && st_r.ale_q && !ale;
    // Data taken when the low strobe rises
    st_nxt.rd_rise = qual && !st_r.rd_n_q && rd_n;
    st_nxt.wr_rise = qual && !st_r.wr_n_q && wr_n;
    st_nxt.rd_active = !cs_n && port_on && !rd_n;
    // Byte seen the cycle before the edge, still stable
    st_nxt.byte_val = st_r.data_q;
    // Group select ignored in shared mode
    if (shared)
      st_nxt.grp_sel = 1'b0;
    else if (sel_src)
      st_nxt.grp_sel = st_r.abit_q;
    else
      st_nxt.grp_sel = st_r.ale_q;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '{rd_n_q: 1'b1, wr_n_q: 1'b1, cs_n_q: 1'b1,
                default: '0};
    else
      st_r <= st_nxt;
  end

  assign ev.ale_fall  = st_r.ale_fall;
  assign ev.rd_rise   = st_r.rd_rise;
  assign ev.wr_rise   = st_r.wr_rise;
  assign ev.rd_active = st_r.rd_active;
  assign ev.grp_sel   = st_r.grp_sel;
  assign ev.byte_val  = st_r.byte_val;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  AST_CS_GATE: assert property (
    (cs_n || !port_on) |=> ##1 !(st_r.rd_rise || st_r.wr_rise))
    else $error("strobe accepted while deselected");
  AST_WR_EDGE: assert property (
    st_r.wr_rise |-> $past(st_r.wr_n_q, 1) == 1'b0)
    else $error("write pulse without low strobe");

endmodule : host_pin_sampler

/* File: hdl/cpu_reg_decode.sv */
`timescale 1ns/1ns
`include "slave_port_cfg.svh"
module cpu_reg_decode
  import slave_port_pkg::*;
(
  input  wire logic        clk_sys,   // System clock
  input  wire logic        sys_rst,   // Async reset
  input  wire logic [15:0] cpu_addr,  // Slave address
  input  wire logic        cpu_wr,    // Write request
  input  wire logic        cpu_rd,    // Read request
  input  wire logic [7:0]  cpu_wdata, // Write data
  cpu_access_if.src        acc        // Decoded access
);

  // Register address table, in index order
  localparam logic [15:0] REG_ADDR [NUM_REGS] =
    '{`ADDR_CMD, `ADDR_STAT, `ADDR_CTRL, `ADDR_IN, `ADDR_OUT};

  decode_st_t          st_r;   // Registered state
  decode_st_t          st_nxt; // Next state
  logic [NUM_REGS-1:0] hit;    // Address match

  // ----------------------------------------
  // Per-register address match
  // ----------------------------------------
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_hit
    assign hit[i] = (cpu_addr == REG_ADDR[i]);
  end

  // Control register only on this slave-side port
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.wr_hit = cpu_wr ? hit : '0;
    st_nxt.rd_hit = cpu_rd ? hit : '0;
    st_nxt.wdata  = cpu_wdata;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign acc.wr_hit = st_r.wr_hit;
  assign acc.rd_hit = st_r.rd_hit;
  assign acc.wdata  = st_r.wdata;

endmodule : cpu_reg_decode

/* File: hdl/slave_port_shared_memory.sv */
`timescale 1ns/1ns
`include "slave_port_cfg.svh"
module slave_port_shared_memory
  import slave_port_pkg::*;
(
  input  wire logic        clk_sys,              // System clock
  input  wire logic        sys_rst,              // Async reset
  // Master side pins
  input  wire logic        address_latch_strobe, // Latch strobe
  input  wire logic        read_strobe_n,        // Read strobe
  input  wire logic        write_strobe_n,       // Write strobe
  input  wire logic        chip_select_n,        // Chip select
  input  wire logic        address_bit_pin,      // Address bit
  input  wire logic [7:0]  bus_data_in,          // Bus in
  output logic      [7:0]  bus_data_out,         // Bus out
  output logic             bus_data_oe,          // Bus drive
  output logic             host_notify,          // Notify pin
  // Slave processor side
  input  wire logic [15:0] cpu_addr,             // Address
  input  wire logic        cpu_wr,               // Write
  input  wire logic        cpu_rd,               // Read
  input  wire logic [7:0]  cpu_wdata,            // Write data
  output logic      [7:0]  cpu_rdata,            // Read data
  output logic             command_full_event,   // Cmd event
  output logic             inbound_full_event,   // In event
  output logic             outbound_empty_event  // Out event
);

  // ----------------------------------------
  // Local signals
  // ----------------------------------------
  core_st_t   st_r;     // Registered state
  core_st_t   st_nxt;   // Next state
  logic       shared;   // Shared mode active
  logic [7:0] status;   // Status byte view

  pin_event_if  ev ();  // Master events
  cpu_access_if acc (); // Slave accesses

  assign shared = st_r.ctrl[`CTRL_SHARED];

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  host_pin_sampler u_sampler
  (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .ale     (address_latch_strobe),
    .rd_n    (read_strobe_n),
    .wr_n    (write_strobe_n),
    .cs_n    (chip_select_n),
    .abit    (address_bit_pin),
    .data_in (bus_data_in),
    .port_on (st_r.ctrl[`CTRL_EN]),
    .shared  (shared),
    .sel_src (st_r.ctrl[`CTRL_SELSRC]),
    .ev      (ev)
  );

  cpu_reg_decode u_decode
  (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .cpu_addr  (cpu_addr),
    .cpu_wr    (cpu_wr),
    .cpu_rd    (cpu_rd),
    .cpu_wdata (cpu_wdata),
    .acc       (acc)
  );

  // ----------------------------------------
  // Status byte assembly
  // ----------------------------------------
  // Top bit reports read/write kind in shared mode
  always_comb
  begin
    status = {st_r.sf, st_r.cbe, st_r.inbound_buffer_empty, st_r.outbound_buffer_full};
    if (shared)
      status[`STAT_TOP] = st_r.smo;
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Order matters: master clears first, slave sets
  // after, so a set in the same cycle is never lost.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.cbf_ev = 1'b0;
    st_nxt.ibf_ev = 1'b0;
    st_nxt.obe_ev = 1'b0;

    // Slave writes to plain registers
    if (acc.wr_hit[RI_CTRL])
      st_nxt.ctrl = acc.wdata & `CTRL_WMASK;
    if (acc.wr_hit[RI_STAT])
      st_nxt.sf = acc.wdata[`STAT_TOP:`STAT_SFLO];
    if (acc.wr_hit[RI_CMD])
      st_nxt.cmd = acc.wdata;
    if (acc.wr_hit[RI_IN])
      st_nxt.inb = acc.wdata;

    // Shared mode: address byte on latch fall
    if (ev.ale_fall)
      st_nxt.cmd = ev.byte_val;

    // Master write
    if (ev.wr_rise)
    begin
      if (ev.grp_sel)
      begin
        // Command byte, standard mode only
        st_nxt.cmd    = ev.byte_val;
        st_nxt.cbe    = 1'b0;
        st_nxt.cbf_ev = 1'b1;
      end
      else
      begin
        // Inbound data; outbound byte untouched
        st_nxt.inb    = ev.byte_val;
        st_nxt.inbound_buffer_empty    = 1'b0;
        st_nxt.ibf_ev = 1'b1;
        st_nxt.smo    = 1'b0;
        if (shared)
          st_nxt.notify = 1'b0;
      end
    end

    // Master read of outbound data; status read is free
    if (ev.rd_rise && !ev.grp_sel)
    begin
      st_nxt.outbound_buffer_full    = 1'b0;
      st_nxt.obe_ev = 1'b1;
      st_nxt.smo    = 1'b1;
      if (shared)
        st_nxt.notify = 1'b0;
    end

    // Slave side sets win over master clears
    if (acc.rd_hit[RI_CMD])
      st_nxt.cbe = 1'b1;
    // Init writes to command and inbound mark both
    // buffers empty; with the outbound write the start-up status reads 111
    if (acc.wr_hit[RI_CMD])
      st_nxt.cbe = 1'b1;
    if (acc.wr_hit[RI_IN])
      st_nxt.inbound_buffer_empty = 1'b1;
    if (acc.rd_hit[RI_IN])
    begin
      st_nxt.inbound_buffer_empty = 1'b1;
      if (shared)
        st_nxt.notify = 1'b1;
    end
    if (acc.wr_hit[RI_OUT])
    begin
      st_nxt.outb = acc.wdata;
      st_nxt.outbound_buffer_full  = 1'b1;
      if (shared)
        st_nxt.notify = 1'b1;
    end

    // Disabled port holds all three flags clear
    if (!st_r.ctrl[`CTRL_EN])
    begin
      st_nxt.cbe = 1'b0;
      st_nxt.inbound_buffer_empty = 1'b0;
      st_nxt.outbound_buffer_full = 1'b0;
    end

    // Standard mode: notify follows masked flags
    if (!shared)
      st_nxt.notify =
        (st_nxt.inbound_buffer_empty & st_r.ctrl[`CTRL_IBEMASK]) |
        (st_nxt.outbound_buffer_full & st_r.ctrl[`CTRL_OBFMASK]);

    // Master read drive: status byte on group select, else old outbound byte (pipelined)
    st_nxt.oe   = ev.rd_active;
    st_nxt.dout = ev.grp_sel ? status : st_r.outb;

    // Slave read data, zero when unmapped
    if (acc.rd_hit[RI_CMD])
      st_nxt.rdata = st_r.cmd;
    else if (acc.rd_hit[RI_STAT])
      st_nxt.rdata = status;
    else if (acc.rd_hit[RI_CTRL])
      st_nxt.rdata = st_r.ctrl;
    else if (acc.rd_hit[RI_IN])
      st_nxt.rdata = st_r.inb;
    else if (acc.rd_hit[RI_OUT])
      st_nxt.rdata = st_r.outb;
    else
      st_nxt.rdata = 8'h00;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Control resets to zero: port off, standard mode
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      st_r <= '{ctrl: `CTRL_RESET, default: '0};
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs, all straight from flip-flops
  // ----------------------------------------
  assign bus_data_out         = st_r.dout;
  assign bus_data_oe          = st_r.oe;
  assign host_notify          = st_r.notify;
  assign cpu_rdata            = st_r.rdata;
  assign command_full_event   = st_r.cbf_ev;
  assign inbound_full_event   = st_r.ibf_ev;
  assign outbound_empty_event = st_r.obe_ev;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Master read of outbound data in shared mode
  sequence s_master_read;
    ev.rd_rise && shared && !ev.grp_sel;
  endsequence

  // Slave fetch written while the port is on
  sequence s_slave_out_wr;
    acc.wr_hit[RI_OUT] && shared && st_r.ctrl[`CTRL_EN];
  endsequence

  AST_ALE_CMD: assert property (
    ev.ale_fall |=> st_r.cmd == $past(ev.byte_val))
    else $error("command byte not loaded on latch fall");
  AST_OBE_EV: assert property (
    s_master_read |=> outbound_empty_event ##1
      !outbound_empty_event)
    else $error("outbound empty event not one pulse");
  AST_IBF_EV: assert property (
    (ev.wr_rise && shared) |=> inbound_full_event &&
      st_r.inb == $past(ev.byte_val))
    else $error("inbound write not taken");
  AST_RD_CLR: assert property (
    (s_master_read and !acc.wr_hit[RI_OUT]) |=>
      !st_r.outbound_buffer_full && !host_notify)
    else $error("master read left flag or notify");
  AST_OUT_WR: assert property (
    s_slave_out_wr |=> host_notify && st_r.outbound_buffer_full &&
      st_r.outb == $past(acc.wdata))
    else $error("slave outbound write not seen");
  AST_IN_RD: assert property (
    (acc.rd_hit[RI_IN] && shared && st_r.ctrl[`CTRL_EN])
      |=> host_notify && st_r.inbound_buffer_empty)
    else $error("slave inbound read left notify low");
  AST_WR_KEEP: assert property (
    (ev.wr_rise && !acc.wr_hit[RI_OUT]) |=> $stable(st_r.outb))
    else $error("write disturbed outbound byte");
  AST_DISABLE: assert property (
    !st_r.ctrl[`CTRL_EN] |=> !st_r.cbe && !st_r.inbound_buffer_empty && !st_r.outbound_buffer_full)
    else $error("flags set while port disabled");
  AST_RSVD: assert property (
    st_r.ctrl[7:5] == 3'b000)
    else $error("reserved control bits set");
  // Slave writes that empty a buffer raise its flag
  AST_CMD_EMPTY: assert property (
    (acc.wr_hit[RI_CMD] && st_r.ctrl[`CTRL_EN]) |=> st_r.cbe)
    else $error("command write left buffer flag clear");
  AST_IN_EMPTY: assert property (
    (acc.wr_hit[RI_IN] && st_r.ctrl[`CTRL_EN]) |=> st_r.inbound_buffer_empty)
    else $error("inbound write left buffer flag clear");
  AST_STD_NOTIFY: assert property (
    (!shared && $stable(st_r.ctrl)) ##1 $stable(st_r.ctrl) |->
      host_notify == ((st_r.inbound_buffer_empty && st_r.ctrl[`CTRL_IBEMASK]) ||
                      (st_r.outbound_buffer_full && st_r.ctrl[`CTRL_OBFMASK])))
    else $error("standard notify not masked flags");

endmodule : slave_port_shared_memory

/* File: verif/host_master_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Master processor on a multiplexed bus
// ----------------------------------------
module host_master_model
(
  input  wire logic       clk_sys,     // System clock
  input  wire logic       host_notify, // Notify pin
  input  wire logic [7:0] bus_data,    // Resolved bus
  output logic            ale,         // Latch strobe
  output logic            rd_n,        // Read strobe
  output logic            wr_n,        // Write strobe
  output logic            cs_n,        // Chip select
  output logic            abit,        // Address bit
  output logic      [7:0] drv,         // Byte driven
  output logic            drv_on       // Drive enable
);
  // Idle: read and write strobes high, latch strobe low, bus released
  initial
  begin
    ale    = 1'b0;
    rd_n   = 1'b1;
    wr_n   = 1'b1;
    cs_n   = 1'b1;
    abit   = 1'b0;
    drv    = 8'h00;
    drv_on = 1'b0;
  end

  // One bus cycle, entered just after a rising edge
  task automatic access(input logic rd, input logic [7:0] a,
    input logic [7:0] d, input logic sel, input logic cs,
    input logic wt, output logic [7:0] q, output logic ok);
    int i;
    int j;
    cs_n   = cs;
    abit   = sel;
    ale    = 1'b1;  // Address byte rides the data lines
    drv    = a;
    drv_on = 1'b1;
    @(posedge clk_sys);
    #1;
    ale    = 1'b0;
    drv    = d;
    drv_on = !rd;   // Bus turned round for a read
    @(posedge clk_sys);
    #1;
    rd_n = !rd;     // One strobe, after the latched address cycle
    wr_n = rd;
    repeat (3) @(posedge clk_sys);
    #1;
    q    = bus_data; // Byte taken just before the strobe rises
    rd_n = 1'b1;
    wr_n = 1'b1;
    @(posedge clk_sys);
    #1;
    cs_n   = 1'b1;
    drv_on = 1'b0;
    i      = 0;
    j      = 0;
    // Hold off until notify has dropped and come back
    while (wt && i < 8 && host_notify !== 1'b0)
    begin
      @(negedge clk_sys);
      i++;
    end
    while (wt && j < 60 && host_notify !== 1'b1)
    begin
      @(negedge clk_sys);
      j++;
    end
    ok = (i < 8) && (j < 60);
    @(posedge clk_sys);
    #1;
  endtask : access
endmodule : host_master_model

/* File: verif/slave_port_shared_memory_tb.sv */
`timescale 1ns/1ns
`include "slave_port_cfg.svh"
module slave_port_shared_memory_tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        clk_sys, sys_rst;          // Clock and reset
  logic        ale, rd_n, wr_n, cs_n;     // Master strobes
  logic        abit, drv_on, bus_oe;      // Select and drives
  logic [7:0]  drv, bus_in, bus_out;      // Bus bytes
  logic        host_notify;               // Notify pin
  logic [15:0] cpu_addr;                  // Slave address
  logic        cpu_wr, cpu_rd;            // Slave strobes
  logic [7:0]  cpu_wdata, cpu_rdata;      // Slave data
  logic        ev_cmd, ev_in, ev_out;     // Events
  logic        fw_on;                     // Firmware active
  logic [7:0]  last_a;                    // Last master offset
  logic [31:0] seed;                      // Random state
  logic [7:0]  mem [256];                 // Firmware window
  logic [7:0]  shadow [256];              // Expected window
  int          n_errors, cmp_count;       // Report counters
  int          n_in, n_out, n_cmd;        // Event counts

  // Port 3 is open-drain with pull-ups: released lines read high
  assign bus_in = bus_oe ? bus_out : (drv_on ? drv : 8'hff);

  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;

  slave_port_shared_memory DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .address_latch_strobe(ale), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .chip_select_n(cs_n),
    .address_bit_pin(abit), .bus_data_in(bus_in),
    .bus_data_out(bus_out), .bus_data_oe(bus_oe),
    .host_notify(host_notify), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .command_full_event(ev_cmd), .inbound_full_event(ev_in),
    .outbound_empty_event(ev_out));

  host_master_model u_master (.clk_sys(clk_sys),
    .host_notify(host_notify), .bus_data(bus_in), .ale(ale),
    .rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .abit(abit), .drv(drv),
    .drv_on(drv_on));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Standard-mode notify level from masks and flags
  function automatic logic [7:0] notify_exp(input logic [1:0] m,
    input logic inbound_buffer_empty, input logic outbound_buffer_full);
    return {7'h00, (inbound_buffer_empty & m[1]) | (outbound_buffer_full & m[0])};
  endfunction : notify_exp

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
               got, exp);
    end
  endtask : chk

  // Slave bus write; effect lands two edges later
  task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
    cpu_addr  = a;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_wr = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : cpu_write

  // Slave bus read; data stands one cycle from edge+2
  task automatic cpu_read(input logic [15:0] a, output logic [7:0] q);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    @(posedge clk_sys);
    #1;
    cpu_rd = 1'b0;
    @(posedge clk_sys);
    #1;
    q = cpu_rdata;
  endtask : cpu_read

  task automatic test_done();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  // Event tally, one count per one-cycle pulse
  always @(negedge clk_sys)
  begin
    n_in  += (ev_in === 1'b1);
    n_out += (ev_out === 1'b1);
    n_cmd += (ev_cmd === 1'b1);
  end

  // ----------------------------------------
  // Slave firmware: services shared events
  // ----------------------------------------
  always @(posedge clk_sys)
    if (fw_on && (ev_in === 1'b1 || ev_out === 1'b1))
    begin : fw
      logic [7:0] c;
      logic [7:0] d;
      logic       is_in;
      is_in = ev_in;
      #1;
      cpu_read(`ADDR_CMD, c);
      chk(c, last_a, "window offset");
      if (is_in)
      begin
        cpu_read(`ADDR_IN, d);   // Frees the master
        mem[c] = d;
      end
      else
        cpu_write(`ADDR_OUT, mem[c]); // Fetch for next read
    end

  // Watchdog: whole run is under a thousand cycles
  initial
  begin
    #200000;
    n_errors++;
    test_done();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin : main
    logic [7:0] q, exp_rd, a;
    logic       ok, rd;
    int         k, n_rd, n_wr;
    {sys_rst, cpu_wr, cpu_rd, fw_on} = 4'b1000;
    {cpu_addr, cpu_wdata, last_a} = 32'h0;
    {n_errors, cmp_count, n_in, n_out, n_cmd, n_rd, n_wr} = '0;
    seed = 32'hfd7fe912;
    for (k = 0; k < 256; k++)
    begin
      seed   = xs(seed);
      mem[k] = seed[7:0];
    end
    shadow = mem;
    repeat (20) @(posedge clk_sys);
    #1;
    sys_rst = 1'b0;
    @(posedge clk_sys);
    #1;
    chk({6'h00, host_notify, bus_oe}, 8'h00, "reset pins");
    cpu_read(`ADDR_CTRL, q);
    chk(q, 8'h00, "control reset");
    cpu_write(`ADDR_CTRL, 8'hff);
    cpu_read(`ADDR_CTRL, q);
    chk(q, 8'h1f, "reserved bits");
    // Strobes while disabled, then while deselected
    cpu_write(`ADDR_CTRL, 8'h00);
    u_master.access(1'b0, 8'h12, 8'h34, 1'b0, 1'b0, 1'b0, q, ok);
    cpu_write(`ADDR_CTRL, 8'h1b);
    u_master.access(1'b0, 8'h12, 8'h34, 1'b0, 1'b1, 1'b0, q, ok);
    repeat (4) @(posedge clk_sys);
    #1;
    chk(8'(n_in + n_out + n_cmd), 8'h00, "ignored strobes");
    // Shared-mode initialisation leaves all three flags set
    cpu_write(`ADDR_OUT, 8'hff);
    cpu_write(`ADDR_CMD, 8'h00);
    cpu_write(`ADDR_IN, 8'h00);
    cpu_read(`ADDR_STAT, q);
    chk({5'h00, q[2:0]}, 8'h07, "init flags");
    chk({7'h00, host_notify}, 8'h01, "notify after fill");
    // Random shared traffic; first reads back to back, then a write
    // to the pending read's offset must not disturb it
    fw_on  = 1'b1;
    exp_rd = 8'hff;
    for (k = 0; k < 40; k++)
    begin
      seed = xs(seed);
      rd   = seed[8] | (k < 2) | (k == 3);
      a    = (k == 2) ? last_a : seed[7:0];
      if (k == 2)
        rd = 1'b0;
      last_a = a;
      u_master.access(rd, a, seed[23:16], 1'b0, 1'b0, 1'b1, q, ok);
      chk({7'h00, ok}, 8'h01, "notify handshake");
      if (rd)
      begin
        chk(q, exp_rd, "pipelined read");
        exp_rd = shadow[a];
        n_rd++;
      end
      else
      begin
        shadow[a] = seed[23:16];
        n_wr++;
      end
    end
    fw_on = 1'b0;
    chk(8'(n_in), 8'(n_wr), "inbound events");
    chk(8'(n_out), 8'(n_rd), "outbound events");
    for (k = 0; k < 256; k++)
      chk(mem[k], shadow[k], "window byte");
    cpu_read(`ADDR_CTRL, q);
    chk(q, 8'h1b, "control untouched");
    // Standard mode, group select from the address bit pin
    cpu_write(`ADDR_CTRL, 8'h0f);
    u_master.access(1'b0, 8'h00, 8'h5a, 1'b1, 1'b0, 1'b0, q, ok);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(8'(n_cmd), 8'h01, "command event");
    cpu_read(`ADDR_CMD, q);
    chk(q, 8'h5a, "command byte");
    cpu_write(`ADDR_OUT, 8'hc3);
    cpu_read(`ADDR_IN, q);
    u_master.access(1'b0, 8'h00, 8'h77, 1'b0, 1'b0, 1'b0, q, ok);
    repeat (3) @(posedge clk_sys);
    #1;
    cpu_read(`ADDR_STAT, q);
    chk({6'h00, q[1:0]}, 8'h01, "inbound cleared");
    // Every mask combination against ibe=0, obf=1
    for (k = 0; k < 4; k++)
    begin
      cpu_write(`ADDR_CTRL, 8'h0c | 8'(k));
      repeat (2) @(posedge clk_sys);
      #1;
      chk({7'h00, host_notify}, notify_exp(2'(k), 1'b0, 1'b1),
          "mask");
    end
    u_master.access(1'b1, 8'h00, 8'h00, 1'b0, 1'b0, 1'b0, q, ok);
    chk(q, 8'hc3, "outbound read");
    repeat (3) @(posedge clk_sys);
    #1;
    chk({7'h00, host_notify}, notify_exp(2'h3, 1'b0, 1'b0),
        "read clears");
    // Disabling clears the flags even when set
    cpu_write(`ADDR_OUT, 8'h11);
    cpu_read(`ADDR_CMD, q);
    cpu_write(`ADDR_CTRL, 8'h03);
    cpu_read(`ADDR_STAT, q);
    chk({5'h00, q[2:0]}, 8'h00, "disable clears");
    test_done();
  end
endmodule : slave_port_shared_memory_tb
